/* File: hdl/vfcgl_fifo.sv */
`timescale 1ns/100ps
module vfcgl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic ready_reg;
  wire push = in_valid_i & ready_reg;
  wire pop = out_valid_o & out_ready_i;

  // Ready comes from a flop so the source never sees a combinational path from the sink.
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o = ready_reg;
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= (count_next != FULL_COUNT);
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule

/* File: hdl/vfcgl_pkg.sv */
package vfcgl_pkg;

  // Target address: upper six bits fixed, then one free bit, then read/write.
  localparam logic [5:0] I2C_ADDR_HI = 6'h16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  localparam logic [7:0] REG_REVISION = 8'h00;
  localparam logic [7:0] REG_VIDEO_INPUT_MODE = 8'h01;
  localparam logic [7:0] REG_SERCTL = 8'h02;
  localparam logic [7:0] REG_LUT_ADDR = 8'h03;
  localparam logic [7:0] REG_LUT_DATA_LO = 8'h04;
  localparam logic [7:0] REG_LUT_DATA_HI = 8'h05;

  localparam int VM_INTERLACE_BIT = 2;
  localparam int VM_VERTICAL_SYNC_POLARITY_BIT = 1;
  localparam int VM_HORIZONTAL_SYNC_POLARITY_BIT = 0;
  localparam int SC_PRBS_BIT = 2;
  localparam int SC_ALIGN_BIT = 1;
  localparam int SC_SKEW_BIT = 0;
  localparam logic [7:0] VIDEO_INPUT_MODE_RESET = 8'h00;
  localparam logic [7:0] SERCTL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h07;
  localparam logic [7:0] RD_ZERO = 8'h00;

  localparam int LUT_DEPTH = 256;
  localparam int LUT_AW = 8;
  localparam int LUT_WIDTH = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int LANE_COUNT = 5;
  localparam int PRBS_LANE = 4;
  localparam int ALIGN_LANE = 2;
  localparam logic [6:0] PRBS_SEED = 7'h7f;
  localparam logic [6:0] ALIGN_WORD = 7'h63;

  typedef struct packed {
    logic field;
    logic vsync;
    logic hsync;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vfcgl_pixel_t;

  typedef struct packed {
    logic enable;
    logic vsync;
    logic hsync;
    logic [LUT_WIDTH-1:0] red;
    logic [LUT_WIDTH-1:0] green;
    logic [LUT_WIDTH-1:0] blue;
  } vfcgl_disp_t;

  typedef enum {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR, ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
  } vfcgl_i2c_state_t;

  function automatic logic [LUT_WIDTH-1:0] gray10(input logic [LUT_WIDTH-1:0] bin);
    gray10 = bin ^ (bin >> 1);
  endfunction

endpackage

/* File: hdl/vfcgl_top.sv */
`timescale 1ns/100ps
module vfcgl_top #(
  parameter logic [2:0] REVISION = 3'h5
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire vfcgl_pkg::vfcgl_pixel_t pix_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  output vfcgl_pkg::vfcgl_disp_t disp_o,
  output logic disp_valid_o,
  input wire logic disp_ready_i,
  input wire logic [vfcgl_pkg::LANE_COUNT-1:0] lane_data_i,
  input wire logic lane_clk_i,
  input wire logic sync_or_align_input_i,
  output logic [vfcgl_pkg::LANE_COUNT-1:0] serial_data_lane_o,
  output logic serial_clk_o
);
  // The revision value is arbitrary.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic align_s1, align_s2;
  vfcgl_pkg::vfcgl_i2c_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] tx_reg, tx_next;
  logic sda_oe_reg, sda_oe_next;
  logic sda_o_reg;
  logic rw_reg, rw_next;
  logic nack_reg, nack_next;
  logic [7:0] ptr_reg;
  logic [7:0] vid_mode_reg;
  logic [7:0] serctl_reg;
  logic [vfcgl_pkg::LUT_AW-1:0] lut_addr_reg;
  logic [7:0] lut_lo_reg;
  logic [vfcgl_pkg::LUT_WIDTH-1:0] lut_reg [vfcgl_pkg::LUT_DEPTH];

  // The pins are asynchronous; every reader sees only the second stage or later.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {align_s1, align_s2} <= 2'h0;
    end
    else
    begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
      {align_s1, align_s2} <= {sync_or_align_input_i, align_s1};
    end
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire byte_full = (cnt_reg == vfcgl_pkg::BYTE_BITS);
  wire shift_state = (state_reg == vfcgl_pkg::ST_ADDR) | (state_reg == vfcgl_pkg::ST_PTR)
                     | (state_reg == vfcgl_pkg::ST_WR);
  wire addr_match = (sh_reg[7:2] == vfcgl_pkg::I2C_ADDR_HI);
  wire ptr_load = scl_fall & (state_reg == vfcgl_pkg::ST_PTR) & byte_full;
  wire reg_wr = scl_fall & (state_reg == vfcgl_pkg::ST_WR) & byte_full;
  wire rd_load = scl_fall & (((state_reg == vfcgl_pkg::ST_ACK_ADDR) & rw_reg)
                 | ((state_reg == vfcgl_pkg::ST_RD_ACK) & ~nack_reg));
  wire wr_video_input_mode = reg_wr & (ptr_reg == vfcgl_pkg::REG_VIDEO_INPUT_MODE);
  wire wr_serctl = reg_wr & (ptr_reg == vfcgl_pkg::REG_SERCTL);
  wire wr_lut_addr = reg_wr & (ptr_reg == vfcgl_pkg::REG_LUT_ADDR);
  wire wr_lut_lo = reg_wr & (ptr_reg == vfcgl_pkg::REG_LUT_DATA_LO);
  wire wr_lut_hi = reg_wr & (ptr_reg == vfcgl_pkg::REG_LUT_DATA_HI);
  wire rd_lut_hi = rd_load & (ptr_reg == vfcgl_pkg::REG_LUT_DATA_HI);
  wire [vfcgl_pkg::LUT_WIDTH-1:0] lut_wr_word = {sh_reg[1:0], lut_lo_reg};
  wire [vfcgl_pkg::LUT_WIDTH-1:0] lut_rd_word = lut_reg[lut_addr_reg];

  // Reads return plain binary; the high byte carries the top two bits only.
  wire [7:0] rd_byte =
    (ptr_reg == vfcgl_pkg::REG_REVISION) ? {5'h00, REVISION} :
    (ptr_reg == vfcgl_pkg::REG_VIDEO_INPUT_MODE) ? vid_mode_reg :
    (ptr_reg == vfcgl_pkg::REG_SERCTL) ? serctl_reg :
    (ptr_reg == vfcgl_pkg::REG_LUT_ADDR) ? lut_addr_reg :
    (ptr_reg == vfcgl_pkg::REG_LUT_DATA_LO) ? lut_rd_word[7:0] :
    (ptr_reg == vfcgl_pkg::REG_LUT_DATA_HI) ? {6'h00, lut_rd_word[9:8]} :
    vfcgl_pkg::RD_ZERO;

  // Bits are taken on a rising clock; the line moves after a falling one, or is freed on a start or stop.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    sda_oe_next = sda_oe_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    if (start_det)
    begin
      state_next = vfcgl_pkg::ST_ADDR;
      cnt_next = '0;
      sda_oe_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next = vfcgl_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end
    else if (scl_rise)
    begin
      if (shift_state && !byte_full)
      begin
        sh_next = {sh_reg[6:0], sda_s2};
        cnt_next = cnt_reg + 4'h1;
      end
      if (state_reg == vfcgl_pkg::ST_RD_ACK)
      begin
        nack_next = sda_s2;
      end
    end
    else if (scl_fall)
    begin
      case (state_reg)
        vfcgl_pkg::ST_ADDR:
        begin
          if (byte_full && addr_match)
          begin
            state_next = vfcgl_pkg::ST_ACK_ADDR;
            sda_oe_next = 1'b1;
            rw_next = sh_reg[0];
          end
          else if (byte_full)
          begin
            state_next = vfcgl_pkg::ST_IDLE;
          end
        end
        vfcgl_pkg::ST_ACK_ADDR:
        begin
          cnt_next = '0;
          if (rw_reg)
          begin
            state_next = vfcgl_pkg::ST_RD;
            tx_next = rd_byte;
            sda_oe_next = ~rd_byte[7];
          end
          else
          begin
            state_next = vfcgl_pkg::ST_PTR;
            sda_oe_next = 1'b0;
          end
        end
        vfcgl_pkg::ST_PTR, vfcgl_pkg::ST_WR:
        begin
          if (byte_full)
          begin
            state_next = (state_reg == vfcgl_pkg::ST_PTR) ? vfcgl_pkg::ST_ACK_PTR
                                                          : vfcgl_pkg::ST_ACK_WR;
            sda_oe_next = 1'b1;
          end
        end
        vfcgl_pkg::ST_ACK_PTR, vfcgl_pkg::ST_ACK_WR:
        begin
          state_next = vfcgl_pkg::ST_WR;
          cnt_next = '0;
          sda_oe_next = 1'b0;
        end
        vfcgl_pkg::ST_RD:
        begin
          if (cnt_reg == vfcgl_pkg::LAST_BIT)
          begin
            state_next = vfcgl_pkg::ST_RD_ACK;
            sda_oe_next = 1'b0;
          end
          else
          begin
            cnt_next = cnt_reg + 4'h1;
            tx_next = {tx_reg[6:0], 1'b0};
            sda_oe_next = ~tx_reg[6];
          end
        end
        vfcgl_pkg::ST_RD_ACK:
        begin
          if (nack_reg)
          begin
            state_next = vfcgl_pkg::ST_IDLE;
          end
          else
          begin
            state_next = vfcgl_pkg::ST_RD;
            cnt_next = '0;
            tx_next = rd_byte;
            sda_oe_next = ~rd_byte[7];
          end
        end
        default:
        begin
          state_next = vfcgl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= vfcgl_pkg::ST_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      sda_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      sda_oe_reg <= sda_oe_next;
      sda_o_reg <= 1'b0;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe_o = sda_oe_reg;

  sequence s_addr_byte_match;
    (state_reg == vfcgl_pkg::ST_ADDR) && scl_fall && byte_full && addr_match;
  endsequence
  sequence s_addr_ack_held;
    (sda_oe_reg && state_reg == vfcgl_pkg::ST_ACK_ADDR);
  endsequence
  chk_addr_ack_drive: assert property (s_addr_byte_match |=> s_addr_ack_held)
    else $error("Matching address was not acknowledged.");
  chk_addr_miss_idle: assert property (
    (state_reg == vfcgl_pkg::ST_ADDR && scl_fall && byte_full && !addr_match && !start_det)
    |=> (state_reg == vfcgl_pkg::ST_IDLE && !sda_oe_reg))
    else $error("Foreign address was not ignored.");
  chk_sda_scl_low: assert property (
    ($changed(sda_oe_reg) && !$past(start_det) && !$past(stop_det)) |-> !scl_s2)
    else $error("Data line moved while the bus clock was high.");

  // Register pointer auto-increments after every byte written or read, so consecutive registers stream in one transfer.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      ptr_reg <= '0;
    end
    else if (ptr_load)
    begin
      ptr_reg <= sh_reg;
    end
    else if (reg_wr || rd_load)
    begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      vid_mode_reg <= vfcgl_pkg::VIDEO_INPUT_MODE_RESET;
      serctl_reg <= vfcgl_pkg::SERCTL_RESET;
      lut_lo_reg <= '0;
    end
    else
    begin
      vid_mode_reg <= wr_video_input_mode ? (sh_reg & vfcgl_pkg::CTRL_MASK) : vid_mode_reg;
      serctl_reg <= wr_serctl ? (sh_reg & vfcgl_pkg::CTRL_MASK) : serctl_reg;
      lut_lo_reg <= wr_lut_lo ? sh_reg : lut_lo_reg;
    end
  end

  chk_rev_write_ignored: assert property (
    (reg_wr && ptr_reg == vfcgl_pkg::REG_REVISION)
    |=> ($stable(vid_mode_reg) && $stable(serctl_reg) && $stable(lut_addr_reg)))
    else $error("Write to the revision register changed state.");

  // The table address steps after each high byte, written or read.
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      lut_addr_reg <= '0;
    end
    else if (wr_lut_addr)
    begin
      lut_addr_reg <= sh_reg;
    end
    else if (wr_lut_hi || rd_lut_hi)
    begin
      lut_addr_reg <= lut_addr_reg + 8'h01;
    end
  end

  // The table has no reset; the master loads the entries it uses after power up.
  always_ff @(posedge core_clk_i)
  begin
    if (wr_lut_hi)
    begin
      lut_reg[lut_addr_reg] <= lut_wr_word;
    end
  end

  chk_lut_entry_store: assert property (
    wr_lut_hi |=> (lut_reg[$past(lut_addr_reg)] == $past(lut_wr_word)))
    else $error("Table entry was not stored at the addressed slot.");

  vfcgl_pkg::vfcgl_pixel_t fifo_pix;
  vfcgl_pkg::vfcgl_disp_t disp_reg, disp_next;
  logic fifo_valid;
  logic disp_valid_reg;
  wire fifo_rd_ready = ~disp_valid_reg | disp_ready_i;
  wire load_out = fifo_valid & fifo_rd_ready;

  vfcgl_fifo #(
    .WIDTH($bits(vfcgl_pkg::vfcgl_pixel_t)),
    .DEPTH(vfcgl_pkg::FIFO_DEPTH)
  ) u_pix_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .in_data_i(pix_i),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .out_data_o(fifo_pix),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_rd_ready)
  );

  wire [vfcgl_pkg::LUT_WIDTH-1:0] lut_red_bin = lut_reg[fifo_pix.red];
  wire [vfcgl_pkg::LUT_WIDTH-1:0] lut_green_bin = lut_reg[fifo_pix.green];
  wire [vfcgl_pkg::LUT_WIDTH-1:0] lut_blue_bin = lut_reg[fifo_pix.blue];
  wire interlace_enable = vid_mode_reg[vfcgl_pkg::VM_INTERLACE_BIT];
  wire vertical_sync_polarity = vid_mode_reg[vfcgl_pkg::VM_VERTICAL_SYNC_POLARITY_BIT];
  wire horizontal_sync_polarity = vid_mode_reg[vfcgl_pkg::VM_HORIZONTAL_SYNC_POLARITY_BIT];

  // Syncs leave active high whatever polarity the source uses.
  assign disp_next.enable = interlace_enable & fifo_pix.field;
  assign disp_next.vsync = fifo_pix.vsync ~^ vertical_sync_polarity;
  assign disp_next.hsync = fifo_pix.hsync ~^ horizontal_sync_polarity;
  assign disp_next.red = vfcgl_pkg::gray10(lut_red_bin);
  assign disp_next.green = vfcgl_pkg::gray10(lut_green_bin);
  assign disp_next.blue = vfcgl_pkg::gray10(lut_blue_bin);

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      disp_reg <= '0;
      disp_valid_reg <= 1'b0;
    end
    else
    begin
      disp_reg <= load_out ? disp_next : disp_reg;
      disp_valid_reg <= load_out | (disp_valid_reg & ~disp_ready_i);
    end
  end

  assign disp_o = disp_reg;
  assign disp_valid_o = disp_valid_reg;

  chk_field_to_enable: assert property (
    load_out |=> (disp_reg.enable == ($past(fifo_pix.field) && $past(interlace_enable))))
    else $error("Field was not routed to the enable output.");
  chk_vsync_polarity: assert property (
    load_out |=> (disp_reg.vsync == ($past(fifo_pix.vsync) ~^ $past(vertical_sync_polarity))))
    else $error("Vertical sync polarity was not applied.");
  chk_hsync_polarity: assert property (
    load_out |=> (disp_reg.hsync == ($past(fifo_pix.hsync) ~^ $past(horizontal_sync_polarity))))
    else $error("Horizontal sync polarity was not applied.");
  chk_same_curve_rgb: assert property (
    (load_out && fifo_pix.red == fifo_pix.blue) |=> (disp_reg.red == disp_reg.blue))
    else $error("Channels do not share one curve.");
  chk_gray_out_code: assert property (
    load_out |=> (disp_reg.green == $past(lut_green_bin ^ (lut_green_bin >> 1))))
    else $error("Display data is not the Gray form of the entry.");

  logic [6:0] prbs_reg;
  logic [6:0] align_reg;
  logic toggle_reg;
  logic [vfcgl_pkg::LANE_COUNT-1:0] lane_reg;
  logic lane_clk_reg;
  wire pseudo_random_test_enable = serctl_reg[vfcgl_pkg::SC_PRBS_BIT];
  wire align_pattern_enable = serctl_reg[vfcgl_pkg::SC_ALIGN_BIT];
  wire skew_training_enable = serctl_reg[vfcgl_pkg::SC_SKEW_BIT];
  wire align_now = align_pattern_enable & align_s2;
  logic [vfcgl_pkg::LANE_COUNT-1:0] lane_normal;
  always_comb
  begin
    lane_normal = lane_data_i;
    lane_normal[vfcgl_pkg::PRBS_LANE] = pseudo_random_test_enable ? prbs_reg[6]
                                        : lane_data_i[vfcgl_pkg::PRBS_LANE];
    lane_normal[vfcgl_pkg::ALIGN_LANE] = align_now ? align_reg[6]
                                         : lane_data_i[vfcgl_pkg::ALIGN_LANE];
  end
  // Skew training overrides every other lane mode, clock included.
  wire [vfcgl_pkg::LANE_COUNT-1:0] lane_next =
    skew_training_enable ? {vfcgl_pkg::LANE_COUNT{toggle_reg}} : lane_normal;
  wire lane_clk_next = skew_training_enable ? toggle_reg : lane_clk_i;

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      prbs_reg <= vfcgl_pkg::PRBS_SEED;
      align_reg <= vfcgl_pkg::ALIGN_WORD;
      toggle_reg <= 1'b0;
      lane_reg <= '0;
      lane_clk_reg <= 1'b0;
    end
    else
    begin
      prbs_reg <= {prbs_reg[5:0], prbs_reg[6] ^ prbs_reg[5]};
      align_reg <= {align_reg[5:0], align_reg[6]};
      toggle_reg <= ~toggle_reg;
      lane_reg <= lane_next;
      lane_clk_reg <= lane_clk_next;
    end
  end

  assign serial_data_lane_o = lane_reg;
  assign serial_clk_o = lane_clk_reg;

  chk_prbs_lane_four: assert property (
    (pseudo_random_test_enable && !skew_training_enable)
    |=> (serial_data_lane_o[vfcgl_pkg::PRBS_LANE] == $past(prbs_reg[6])))
    else $error("Lane four does not carry the PRBS.");
  chk_align_lane_two: assert property (
    (align_now && !skew_training_enable)
    |=> (serial_data_lane_o[vfcgl_pkg::ALIGN_LANE] == $past(align_reg[6])))
    else $error("Lane two does not carry the align word.");
  chk_skew_pattern: assert property (
    (skew_training_enable [*2]) |=> (serial_clk_o != $past(serial_clk_o)))
    else $error("Skew clock pattern does not toggle.");
endmodule

/* File: tb/vfcgl_i2c_master.sv */
`timescale 1ns/100ps
// Bus master model; its clock stands still between frames.
module vfcgl_i2c_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // A 320 ns bit gives each clock phase four core cycles.
  task automatic bit_x(input logic b, output logic r);
    #40 sda_low_o = ~b;
    #120 scl_o = 1'b1;
    #150 r = sda_i;
    #10 scl_o = 1'b0;
  endtask
  // A repeated start lets the target free the line before the clock rises again.
  task automatic start();
    #40 sda_low_o = 1'b0;
    #120 scl_o = 1'b1;
    #160 sda_low_o = 1'b1;
    #160 scl_o = 1'b0;
  endtask
  task automatic stop();
    #40 sda_low_o = 1'b1;
    #120 scl_o = 1'b1;
    #160 sda_low_o = 1'b0;
    #160;
  endtask
  // Sends d first bit first, then frees the line for the acknowledge.
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
endmodule

/* File: tb/vfcgl_top_tb.sv */
`timescale 1ns/100ps
module vfcgl_top_tb;
  localparam logic [2:0] SILICON_REVISION_FIELD = 3'h3;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic scl, m_low, sda, sda_oe, pix_ready, disp_valid, sclk, k;
  logic pix_valid = 1'b0;
  logic disp_ready = 1'b0;
  logic align_pin = 1'b0;
  logic [4:0] lane_in = 5'h0a;
  logic [4:0] lanes;
  logic [7:0] q, r8;
  logic [9:0] e;
  logic sda_drv;
  logic lane_clk = 1'b1;
  vfcgl_pkg::vfcgl_pixel_t pix = '0;
  vfcgl_pkg::vfcgl_disp_t disp;
  int fails = 0;
  int n_tests = 0;
  int c;
  assign sda = ~(m_low | sda_oe);
  always #20 core_clk_i = ~core_clk_i;
  vfcgl_i2c_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  vfcgl_top #(.REVISION(SILICON_REVISION_FIELD)) DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe), .pix_i(pix), .pix_valid_i(pix_valid),
    .pix_ready_o(pix_ready), .disp_o(disp), .disp_valid_o(disp_valid),
    .disp_ready_i(disp_ready), .lane_data_i(lane_in), .lane_clk_i(lane_clk),
    .sync_or_align_input_i(align_pin), .serial_data_lane_o(lanes), .serial_clk_o(sclk));
  function automatic logic [9:0] ev(input int i);
    ev = (i == 9) ? 10'h3ff : 10'(i * 101 + 7);
  endfunction
  function automatic logic [7:0] ix(input int i);
    ix = (i == 9) ? 8'hff : 8'(i);
  endfunction
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic addr(input logic [7:0] a);
    m.start();
    m.xfer(a, q, k);
    chk(k, a[7:2] == 6'h16);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr(8'h58);
    m.xfer(a, q, k);
    m.xfer(d, q, k);
    chk(k, 1'b1);
    m.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr(8'h58);
    m.xfer(a, q, k);
    addr(8'h59);
    m.xfer(8'hff, d, k);
    m.stop();
  endtask
  task automatic push(input logic [7:0] x, input logic [2:0] s);
    pix = {s, x, x, x};
    pix_valid = 1'b1;
    while (pix_ready !== 1'b1) cyc(1);
    cyc(1);
    pix_valid = 1'b0;
  endtask
  task automatic pop(input logic [9:0] e, input logic [2:0] s);
    logic [9:0] g;
    g = e ^ (e >> 1);
    disp_ready = 1'b1;
    for (int i = 0; i < 40 && disp_valid !== 1'b1; i++) cyc(1);
    chk(disp_valid, 1'b1);
    chk(disp, {s, g, g, g});
    cyc(1);
    disp_ready = 1'b0;
  endtask
  initial
  begin
    #2000000;
    fails++;
    print_verdict();
  end
  initial
  begin
    cyc(3);
    srst_i = 1'b0;
    cyc(3);
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    rd(8'h01, r8);
    chk(r8, 8'h00);
    rd(8'h02, r8);
    chk(r8, 8'h00);
    chk(sda_drv, 1'b0);
    wr(8'h00, 8'hff);
    rd(8'h00, r8);
    chk(r8, {5'h00, SILICON_REVISION_FIELD});
    rd(8'h10, r8);
    chk(r8, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, r8);
    chk(r8, 8'h07);
    addr(8'h5c);
    m.stop();
    addr(8'h5a);
    m.stop();
    for (int i = 0; i < 10; i++)
    begin
      e = ev(i);
      wr(8'h03, ix(i));
      wr(8'h04, e[7:0]);
      wr(8'h05, {6'h00, e[9:8]});
    end
    for (int i = 0; i < 10; i++)
    begin
      e = ev(i);
      wr(8'h03, ix(i));
      rd(8'h04, r8);
      chk(r8, e[7:0]);
      rd(8'h05, r8);
      chk(r8, {6'h00, e[9:8]});
    end
    wr(8'h01, 8'h00);
    push(ix(0), 3'b001);
    pop(ev(0), 3'b010);
    wr(8'h01, 8'h07);
    push(ix(9), 3'b101);
    pop(ev(9), 3'b101);
    wr(8'h01, 8'h03);
    push(ix(9), 3'b101);
    pop(ev(9), 3'b001);
    // The sink stalls, so the buffer and the output stage both fill.
    c = 0;
    pix_valid = 1'b1;
    for (int j = 0; j < 14; j++)
    begin
      pix = {3'b000, ix(c), ix(c), ix(c)};
      if (pix_ready === 1'b1)
        c++;
      cyc(1);
    end
    pix_valid = 1'b0;
    chk(c, 9);
    chk(pix_ready, 1'b0);
    for (int j = 0; j < 9; j++) pop(ev(j), 3'b000);
    chk(disp_valid, 1'b0);
    chk(lanes, 5'h0a);
    chk(sclk, 1'b1);
    lane_clk = 1'b0;
    cyc(2);
    chk(sclk, 1'b0);
    wr(8'h02, 8'h04);
    c = 0;
    repeat (127)
    begin
      cyc(1);
      c += int'(lanes[4] === 1'b1);
    end
    chk(c, 64);
    chk(lanes[3:0], 4'ha);
    wr(8'h02, 8'h02);
    align_pin = 1'b1;
    cyc(4);
    c = 0;
    repeat (7)
    begin
      cyc(1);
      c += int'(lanes[2] === 1'b1);
    end
    chk(c, 4);
    align_pin = 1'b0;
    cyc(4);
    chk(lanes, 5'h0a);
    wr(8'h02, 8'h01);
    c = 0;
    repeat (8)
    begin
      k = sclk;
      cyc(1);
      c += int'(sclk !== k);
    end
    chk(c, 8);
    chk(lanes, {5{sclk}});
    print_verdict();
  end
endmodule
